// ==== inc/tvadc_pkg.sv ====
// Purpose: Shared types and constants for the triple video converter control logic.
// Assumes: Analog inputs arrive as 9-bit levels in half-LSB units from a front-end model.
// Notes:   Widths, offsets, codes and reset values are named here; the other files also write some of them out as literals.
//
// Notes on behaviour
// - Sample on falling edge, output 2.5 cycles later.
// - Chip select low drives outputs, high floats.
// - Three channels share clock and sync inputs.
// - Line sync steps the dither counter each line.
// - Every second frame sync resets the counter.
// - Frame sync held low stops dither counter.
// - Dither offset moves in half-LSB steps.
// - Whole-LSB offsets subtracted from output codes.
// - Output range 00..FE or 01..FF by state.
// - Select low: RGB, all clamp to 16.
// - Select high: luma 16, chroma 128.
// - Select open: luma 64, chroma 128.
// - Line sync high integrates input minus reference.
// - Falling line sync latches sign, drives correction.
package tvadc_pkg;

  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int unsigned TVADC_CODE_W      = 8;
  localparam int unsigned TVADC_LEVEL_W     = 9;
  localparam int unsigned TVADC_ACC_W       = 20;
  localparam int unsigned TVADC_DITHER_W    = 2;
  localparam int unsigned TVADC_CLK_NS      = 20;
  // Rising edges between the sampling falling edge and the output edge (2.5 cycles).
  localparam int unsigned TVADC_OUT_EDGES   = 3;

  // ************************************************************
  // Codes, reset values and dither mapping
  // ************************************************************
  localparam logic [7:0] TVADC_CODE_MIN     = 8'h00;
  localparam logic [7:0] TVADC_CODE_MAX     = 8'hFF;
  localparam logic [7:0] TVADC_CODE_LOW_ALT = 8'h01;
  localparam logic [7:0] TVADC_CODE_RST     = 8'h00;
  localparam logic [1:0] TVADC_DITHER_RST   = 2'h0;
  // Offsets in half-LSB units for counter states 0..3.
  localparam logic [1:0] TVADC_OFS_ZERO     = 2'h0;
  localparam logic [1:0] TVADC_OFS_HALF     = 2'h1;
  localparam logic [1:0] TVADC_OFS_WHOLE    = 2'h2;

  // ************************************************************
  // Clamp reference levels in LSB of full range
  // ************************************************************
  localparam logic [7:0] TVADC_CLAMP_16     = 8'h10;
  localparam logic [7:0] TVADC_CLAMP_64     = 8'h40;
  localparam logic [7:0] TVADC_CLAMP_128    = 8'h80;

  // ************************************************************
  // Types
  // ************************************************************
  // Three-level clamp select as decoded from the select pin.
  typedef enum logic [1:0] {
    TVADC_SEL_LOW  = 2'h0,
    TVADC_SEL_HIGH = 2'h1,
    TVADC_SEL_OPEN = 2'h2
  } tvadc_sel_t;

  // Clamp sequencer states, one-hot.
  typedef enum logic [2:0] {
    TVADC_CL_IDLE      = 3'h1,
    TVADC_CL_INTEGRATE = 3'h2,
    TVADC_CL_CORRECT   = 3'h4
  } tvadc_clamp_state_t;

  typedef struct packed {
    logic [TVADC_LEVEL_W-1:0] red;
    logic [TVADC_LEVEL_W-1:0] green;
    logic [TVADC_LEVEL_W-1:0] blue;
  } tvadc_level_t;

  typedef struct packed {
    logic [TVADC_CODE_W-1:0] red;
    logic [TVADC_CODE_W-1:0] green;
    logic [TVADC_CODE_W-1:0] blue;
  } tvadc_code_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } tvadc_flag_t;

endpackage

// ==== logic/tvadc_clamp.sv ====
// Purpose: Line-sync gated clamp sequencer for one channel.
// Assumes: Line sync edges are supplied as one-cycle pulses by the parent.
// Notes:   Sink means the input sits above its reference and must be pulled down.
module tvadc_clamp
  import tvadc_pkg::*;
(
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Sampled level and reference.
  input  wire logic [TVADC_LEVEL_W-1:0] level,
  input  wire logic [TVADC_CODE_W-1:0]  ref_code,
  // Line sync level and edges.
  input  wire logic                     line_high,
  input  wire logic                     line_fall,
  // Correction current requests.
  output logic                          sink,
  output logic                          source
);

  tvadc_clamp_state_t           state;
  tvadc_clamp_state_t           next_state;
  logic signed [TVADC_ACC_W-1:0] acc;
  logic signed [TVADC_ACC_W-1:0] diff;
  logic                          sign_pos;

  // Difference of input and reference, both in half-LSB units.
  assign diff = TVADC_ACC_W'($signed({1'b0, level})) -
                TVADC_ACC_W'($signed({1'b0, ref_code, 1'b0}));

  // Sequencer: integrate while line sync is high, correct after it falls.
  always_comb
  begin
    next_state = state;
    case (state)
      TVADC_CL_IDLE:      if (line_high) next_state = TVADC_CL_INTEGRATE;
      TVADC_CL_INTEGRATE: if (line_fall) next_state = TVADC_CL_CORRECT;
      TVADC_CL_CORRECT:   if (line_high) next_state = TVADC_CL_INTEGRATE;
      default:            next_state = TVADC_CL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= TVADC_CL_IDLE;
    else
      state <= next_state;
  end

  // Integrator restarts at the start of each high phase of line sync.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      acc <= '0;
    else if (next_state == TVADC_CL_INTEGRATE && state != TVADC_CL_INTEGRATE)
      acc <= diff;
    else if (state == TVADC_CL_INTEGRATE && line_high)
      acc <= acc + diff;
  end

  // Sign is latched once, at the falling edge of line sync.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sign_pos <= 1'b0;
    else if (state == TVADC_CL_INTEGRATE && line_fall)
      sign_pos <= (acc > 0);
  end

  // Correction current is applied from the line sync fall until a clock edge registers the next rise.
  assign sink   = (state == TVADC_CL_CORRECT) && sign_pos;
  assign source = (state == TVADC_CL_CORRECT) && !sign_pos;

endmodule // tvadc_clamp

// ==== logic/tvadc_core.sv ====
// Purpose: Digital control of a triple eight-bit video converter.
// Assumes: All sync and select inputs are synchronous to clk; one clock only.
// Notes:   Code outputs use a separate output enable; the pad ring builds the three-state.
module tvadc_core
  import tvadc_pkg::*;
(
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Analog input levels, half-LSB units.
  input  wire logic [TVADC_LEVEL_W-1:0] red_analog_in,
  input  wire logic [TVADC_LEVEL_W-1:0] green_analog_in,
  input  wire logic [TVADC_LEVEL_W-1:0] blue_analog_in,
  // Sync and control inputs.
  input  wire logic                     line_sync_in,
  input  wire logic                     frame_sync_in,
  input  wire tvadc_sel_t               clamp_select,
  input  wire logic                     chip_select_n,
  // Digital code outputs.
  output logic [TVADC_CODE_W-1:0]       red_code_out,
  output logic [TVADC_CODE_W-1:0]       green_code_out,
  output logic [TVADC_CODE_W-1:0]       blue_code_out,
  output logic                          code_oe,
  // Clamp correction currents.
  output tvadc_flag_t                   clamp_sink,
  output tvadc_flag_t                   clamp_source,
  // Dither status.
  output logic [TVADC_DITHER_W-1:0]     dither_state,
  output logic                          dither_running
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Counter state to offset in half-LSB units: 0, half, one, half.
  function automatic logic [1:0] tvadc_offset(input logic [TVADC_DITHER_W-1:0] st);
    logic [1:0] ofs;
    case (st)
      2'h0:    ofs = TVADC_OFS_ZERO;
      2'h1:    ofs = TVADC_OFS_HALF;
      2'h2:    ofs = TVADC_OFS_WHOLE;
      default: ofs = TVADC_OFS_HALF;
    endcase
    return ofs;
  endfunction

  // Quantise a level plus offset, take back whole-LSB offsets, and limit the range.
  function automatic logic [7:0] tvadc_convert(input logic [TVADC_LEVEL_W-1:0] lvl,
                                               input logic [1:0]               ofs);
    logic [9:0] sum;
    logic [8:0] raw;
    logic [7:0] q;
    logic [7:0] res;
    sum = {1'b0, lvl} + {8'h00, ofs};
    raw = sum[9:1];
    q   = raw[8] ? TVADC_CODE_MAX : raw[7:0];
    if (ofs == TVADC_OFS_WHOLE)
    begin
      // Offset of one LSB: q is at least one here, so the result spans 00..FE.
      res = (q == TVADC_CODE_MIN) ? TVADC_CODE_MIN : q - 8'h01;
      if (res == TVADC_CODE_MAX)
        res = TVADC_CODE_MAX - 8'h01;
    end
    else
    begin
      // No whole offset to remove: the result spans 01..FF.
      res = (q == TVADC_CODE_MIN) ? TVADC_CODE_LOW_ALT : q;
    end
    return res;
  endfunction

  // Clamp reference for one channel; luma is the green input.
  function automatic logic [7:0] tvadc_clamp_ref(input tvadc_sel_t sel,
                                                 input logic       is_luma);
    logic [7:0] lvl;
    case (sel)
      TVADC_SEL_LOW:  lvl = TVADC_CLAMP_16;
      TVADC_SEL_HIGH: lvl = is_luma ? TVADC_CLAMP_16 : TVADC_CLAMP_128;
      TVADC_SEL_OPEN: lvl = is_luma ? TVADC_CLAMP_64 : TVADC_CLAMP_128;
      default:        lvl = TVADC_CLAMP_16;
    endcase
    return lvl;
  endfunction

  // ************************************************************
  // Sync edge detection
  // ************************************************************

  logic line_prev;
  logic frame_prev;
  logic line_rise;
  logic line_fall;
  logic frame_fall;

  // Previous levels of the sync inputs.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_prev  <= 1'b0;
      frame_prev <= 1'b1;
    end
    else
    begin
      line_prev  <= line_sync_in;
      frame_prev <= frame_sync_in;
    end
  end

  // One-cycle edge pulses shared by all three channels.
  assign line_rise  = line_sync_in && !line_prev;
  assign line_fall  = !line_sync_in && line_prev;
  assign frame_fall = !frame_sync_in && frame_prev;

  // ************************************************************
  // Dither counter
  // ************************************************************

  logic [TVADC_DITHER_W-1:0] dither_cnt;
  logic [TVADC_DITHER_W-1:0] next_dither_cnt;
  logic                      frame_toggle;
  logic                      frame_reset;
  logic                      line_step;

  // Every second frame pulse resets; a low frame sync stops the count.
  assign frame_reset = frame_fall && frame_toggle;
  assign line_step   = line_rise && frame_sync_in;

  // Reset takes priority over a line step in the same cycle.
  always_comb
  begin
    next_dither_cnt = dither_cnt;
    if (frame_reset)
      next_dither_cnt = TVADC_DITHER_RST;
    else if (line_step)
      next_dither_cnt = dither_cnt + 2'h1;
  end

  // Counter register and the every-second-pulse toggle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dither_cnt   <= TVADC_DITHER_RST;
      frame_toggle <= 1'b0;
    end
    else
    begin
      dither_cnt <= next_dither_cnt;
      if (frame_fall)
        frame_toggle <= !frame_toggle;
    end
  end

  assign dither_state   = dither_cnt;
  assign dither_running = frame_sync_in;

  // ************************************************************
  // Sampling and output pipeline
  // ************************************************************

  tvadc_level_t sample;
  tvadc_code_t  conv;
  tvadc_code_t  stage_a;
  tvadc_code_t  stage_b;
  tvadc_code_t  stage_out;
  logic [1:0]   cur_ofs;

  // Inputs are sensed on the falling edge of the clock.
  always_ff @(negedge clk or negedge resetn)
  begin
    if (!resetn)
      sample <= '0;
    else
      sample <= '{red: red_analog_in, green: green_analog_in,
                  blue: blue_analog_in};
  end

  // Conversion of each channel with the current dither offset.
  assign cur_ofs    = tvadc_offset(dither_cnt);
  assign conv.red   = tvadc_convert(sample.red, cur_ofs);
  assign conv.green = tvadc_convert(sample.green, cur_ofs);
  assign conv.blue  = tvadc_convert(sample.blue, cur_ofs);

  // Three rising edges bring the code out 2.5 cycles after sampling.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_a   <= '0;
      stage_b   <= '0;
      stage_out <= '0;
    end
    else
    begin
      stage_a   <= conv;
      stage_b   <= stage_a;
      stage_out <= stage_b;
    end
  end

  // Registered codes; the enable marks when the pins are driven.
  assign red_code_out   = stage_out.red;
  assign green_code_out = stage_out.green;
  assign blue_code_out  = stage_out.blue;
  assign code_oe        = !chip_select_n;

  // ************************************************************
  // Clamp networks
  // ************************************************************

  logic [TVADC_CODE_W-1:0] ref_red;
  logic [TVADC_CODE_W-1:0] ref_green;
  logic [TVADC_CODE_W-1:0] ref_blue;

  // References from the three-level select; green carries luma.
  assign ref_red   = tvadc_clamp_ref(clamp_select, 1'b0);
  assign ref_green = tvadc_clamp_ref(clamp_select, 1'b1);
  assign ref_blue  = tvadc_clamp_ref(clamp_select, 1'b0);

  // One sequencer per channel, all gated by the same line sync.
  tvadc_clamp u_clamp_red (
    .clk       (clk),
    .resetn    (resetn),
    .level     (sample.red),
    .ref_code  (ref_red),
    .line_high (line_sync_in),
    .line_fall (line_fall),
    .sink      (clamp_sink.red),
    .source    (clamp_source.red)
  );

  tvadc_clamp u_clamp_green (
    .clk       (clk),
    .resetn    (resetn),
    .level     (sample.green),
    .ref_code  (ref_green),
    .line_high (line_sync_in),
    .line_fall (line_fall),
    .sink      (clamp_sink.green),
    .source    (clamp_source.green)
  );

  tvadc_clamp u_clamp_blue (
    .clk       (clk),
    .resetn    (resetn),
    .level     (sample.blue),
    .ref_code  (ref_blue),
    .line_high (line_sync_in),
    .line_fall (line_fall),
    .sink      (clamp_sink.blue),
    .source    (clamp_source.blue)
  );

endmodule // tvadc_core

// ==== test/tvadc_sink_model.sv ====
// Purpose: Downstream logic that takes the converter code bus.
// Assumes: Codes launch at the rising edge; words are taken at the falling edge.
// Notes:   A released bus reads as the inverse of the last driven word.
module tvadc_sink_model
  import tvadc_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Code bus and its enable.
  input  wire tvadc_code_t pins,
  input  wire logic        oe,
  // Last word seen and count of driven words.
  output tvadc_code_t      word,
  output int unsigned      taken
);
  timeunit 1ns;
  timeprecision 100ps;
  tvadc_code_t held = '0;
  // Floating pins never repeat the last word, so a stale read cannot pass.
  wire tvadc_code_t bus = oe ? pins : tvadc_code_t'(~held);
  // Take the bus mid-cycle and count only driven words.
  initial taken = 0;
  always @(negedge clk)
  begin
    word <= bus;
    if (oe)
    begin
      held  <= pins;
      taken <= taken + 1;
    end
  end
endmodule // tvadc_sink_model

// ==== test/tvadc_core_asserts.sv ====
// Purpose: Port checks for the converter control core.
// Assumes: Sync inputs are synchronous to clk.
// Notes:   Helper flops mirror the core's edge detectors and reset values.
module tvadc_core_asserts
  import tvadc_pkg::*;
(
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      resetn,
  // Controls.
  input wire logic                      line_sync_in,
  input wire logic                      frame_sync_in,
  input wire logic                      chip_select_n,
  // Outputs.
  input wire logic [TVADC_CODE_W-1:0]   red_code_out,
  input wire logic [TVADC_CODE_W-1:0]   green_code_out,
  input wire logic [TVADC_CODE_W-1:0]   blue_code_out,
  input wire logic                      code_oe,
  input wire tvadc_flag_t               clamp_sink,
  input wire tvadc_flag_t               clamp_source,
  input wire logic [TVADC_DITHER_W-1:0] dither_state,
  input wire logic                      dither_running
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       lprev;
  logic       fprev;
  logic       tog;
  logic [1:0] warm;
  // Extreme codes that a dither state must rule out.
  wire logic  no_top = red_code_out != 8'hFF && green_code_out != 8'hFF
                       && blue_code_out != 8'hFF;
  wire logic  no_bot = red_code_out != 8'h00 && green_code_out != 8'h00
                       && blue_code_out != 8'h00;
  // Edge history, frame toggle and pipeline fill count, reset like the core.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lprev <= 1'b0;
      fprev <= 1'b1;
      tog   <= 1'b0;
      warm  <= 2'h0;
    end
    else
    begin
      lprev <= line_sync_in;
      fprev <= frame_sync_in;
      tog   <= tog ^ (fprev & ~frame_sync_in);
      warm  <= warm + {1'b0, warm != 2'h3};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  oe_follows_cs_a: assert property (code_oe == !chip_select_n)
    else $error("code_oe disagrees with chip select");
  frame_low_hold_a: assert property (!frame_sync_in && !fprev |=> $stable(dither_state))
    else $error("dither moved with frame sync low");
  line_step_a: assert property (frame_sync_in && fprev && line_sync_in && !lprev
    |=> dither_state == $past(dither_state) + 2'h1)
    else $error("dither did not step on line sync");
  idle_hold_a: assert property (frame_sync_in && !(line_sync_in && !lprev)
    |=> $stable(dither_state))
    else $error("dither moved without line sync");
  second_frame_a: assert property (!frame_sync_in && fprev && tog |=> dither_state == 2'h0)
    else $error("second frame pulse did not clear dither");
  first_frame_a: assert property (!frame_sync_in && fprev && !tog |=> $stable(dither_state))
    else $error("first frame pulse changed dither");
  run_flag_a: assert property (dither_running == frame_sync_in)
    else $error("dither running flag wrong");
  range_whole_a: assert property (warm == 2'h3 && $past(dither_state, 3) == 2'h2 |-> no_top)
    else $error("code FF with whole offset");
  range_other_a: assert property (warm == 2'h3 && $past(dither_state, 3) != 2'h2 |-> no_bot)
    else $error("code 00 without whole offset");
  clamp_quiet_a: assert property (line_sync_in |=> clamp_sink == 3'h0 && clamp_source == 3'h0)
    else $error("correction current during integration");
  clamp_fall_a: assert property (!line_sync_in && lprev |=> (clamp_sink ^ clamp_source) == 3'h7)
    else $error("no single correction after line fall");
  clamp_hold_a: assert property (!line_sync_in && !lprev
    |=> $stable(clamp_sink) && $stable(clamp_source))
    else $error("correction changed while line low");
endmodule // tvadc_core_asserts

bind tvadc_core tvadc_core_asserts chk_u (
  .clk            (clk),
  .resetn         (resetn),
  .line_sync_in   (line_sync_in),
  .frame_sync_in  (frame_sync_in),
  .chip_select_n  (chip_select_n),
  .red_code_out   (red_code_out),
  .green_code_out (green_code_out),
  .blue_code_out  (blue_code_out),
  .code_oe        (code_oe),
  .clamp_sink     (clamp_sink),
  .clamp_source   (clamp_source),
  .dither_state   (dither_state),
  .dither_running (dither_running)
);

// ==== test/tvadc_core_bench.sv ====
// Purpose: Self-checking bench for the converter control core.
// Assumes: Inputs change at the falling edge, where outputs are also read.
// Notes:   Analog levels are 9-bit half-LSB values driven straight in.
module tvadc_core_bench
  import tvadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  tvadc_level_t lv = '0;
  logic         line = 1'b0;
  logic         frame = 1'b1;
  tvadc_sel_t   sel = TVADC_SEL_LOW;
  logic         csn = 1'b0;
  tvadc_code_t  code;
  logic         oe;
  tvadc_flag_t  sink;
  tvadc_flag_t  src;
  logic [1:0]   dstate;
  logic         run;
  tvadc_code_t  word;
  int unsigned  taken;
  logic [1:0]   dexp = 2'h0;
  int           error_cnt = 0;
  int           n_checks = 0;
  // Free-running sample clock.
  initial
  begin
    forever #(TVADC_CLK_NS / 2) clk = ~clk;
  end
  tvadc_core dut_u (.clk(clk), .resetn(resetn), .red_analog_in(lv.red),
    .green_analog_in(lv.green), .blue_analog_in(lv.blue), .line_sync_in(line),
    .frame_sync_in(frame), .clamp_select(sel), .chip_select_n(csn),
    .red_code_out(code.red), .green_code_out(code.green), .blue_code_out(code.blue),
    .code_oe(oe), .clamp_sink(sink), .clamp_source(src), .dither_state(dstate),
    .dither_running(run));
  tvadc_sink_model sink_u (.clk(clk), .pins(code), .oe(oe), .word(word), .taken(taken));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected code: offset map 0, half, one, half; a whole offset is taken back off.
  function automatic logic [7:0] exp_code(input logic [8:0] l, input logic [1:0] st);
    logic [9:0] s;
    logic [7:0] q;
    s = {1'b0, l} + ((st == 2'h2) ? 10'h2 : {9'h0, st[0]});
    q = s[9] ? 8'hFF : s[8:1];
    return (st == 2'h2) ? q - 8'h1 : ((q == 8'h0) ? 8'h1 : q);
  endfunction
  function automatic tvadc_code_t expw(input tvadc_level_t l, input logic [1:0] st);
    return '{exp_code(l.red, st), exp_code(l.green, st), exp_code(l.blue, st)};
  endfunction
  task automatic do_reset();
    resetn <= 1'b0;
    tick(6);
    chk("codes in reset", code, 24'h0);
    resetn <= 1'b1;
    dexp = 2'h0;
    tick(1);
    chk("dither after reset", 24'(dstate), 24'h0);
  endtask
  // Two-cycle pulse, short of the back porch, at a steady line period.
  task automatic line_pulse();
    line <= 1'b1;
    tick(2);
    line <= 1'b0;
    tick(2);
    if (frame)
      dexp = dexp + 2'h1;
  endtask
  task automatic t_dither();
    repeat (5)
    begin
      line_pulse();
      chk("dither step", 24'(dstate), 24'(dexp));
    end
    frame <= 1'b0;
    tick(2);
    chk("running flag", 24'(run), 24'h0);
    chk("first frame pulse", 24'(dstate), 24'(dexp));
    line_pulse();
    chk("dither stopped", 24'(dstate), 24'(dexp));
    frame <= 1'b1;
    tick(1);
    line_pulse();
    chk("dither restarted", 24'(dstate), 24'(dexp));
    frame <= 1'b0;
    tick(2);
    dexp = 2'h0;
    chk("second frame pulse", 24'(dstate), 24'h0);
    frame <= 1'b1;
    tick(1);
  endtask
  task automatic t_conv();
    logic [8:0]   lvls [7] = '{9'h000, 9'h001, 9'h002, 9'h0FF, 9'h100, 9'h1FE, 9'h1FF};
    tvadc_level_t nxt;
    tvadc_code_t  old;
    repeat (4)
    begin
      line_pulse();
      foreach (lvls[i])
      begin
        old = expw(lv, dexp);
        nxt = '{lvls[i], ~lvls[i], {lvls[i][0], lvls[i][8:1]}};
        lv <= nxt;
        tick(3);
        chk("code before latency", code, old);
        tick(1);
        chk("code after latency", code, expw(nxt, dexp));
        tick(1);
        chk("word downstream", word, expw(nxt, dexp));
      end
    end
  endtask
  task automatic t_cs();
    int unsigned n;
    csn <= 1'b1;
    tick(1);
    n = taken;
    chk("oe with select high", 24'(oe), 24'h0);
    tick(3);
    chk("words while released", 24'(taken - n), 24'h0);
    csn <= 1'b0;
    tick(1);
    chk("oe with select low", 24'(oe), 24'h1);
  endtask
  // Level 80 half-LSB sits above 16 and below 64 and 128.
  task automatic t_clamp();
    logic [2:0] pat [4] = '{3'h7, 3'h2, 3'h0, 3'h7};
    lv <= '{9'h050, 9'h050, 9'h050};
    for (int m = 0; m < 4; m++)
    begin
      sel <= tvadc_sel_t'(m);
      tick(1);
      line_pulse();
      chk("sink", 24'(sink), 24'(pat[m]));
      chk("source", 24'(src), {21'h0, ~pat[m]});
      tick(3);
      chk("sink held", 24'(sink), 24'(pat[m]));
    end
    // A large rise then a small dip sums positive, so a last-sample design would source.
    lv <= '{9'h0A0, 9'h0A0, 9'h0A0};
    tick(1);
    line <= 1'b1;
    lv   <= '{9'h010, 9'h010, 9'h010};
    tick(2);
    line <= 1'b0;
    tick(2);
    chk("sink integrated", 24'(sink), 24'h7);
    chk("source integrated", 24'(src), 24'h0);
  endtask
  // Cuts a hung run short and counts it as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence, with a second reset in mid-run.
  initial
  begin
    do_reset();
    t_dither();
    t_conv();
    t_cs();
    t_clamp();
    do_reset();
    t_dither();
    tally_and_finish();
  end
endmodule // tvadc_core_bench
